// ### rtl/linfc_pkg.sv
// Shared constants and types for the LIN transceiver mode and fault control.
// Assumes one 10 MHz clock; the controller and the test bench import this package whole.
package linfc_pkg;

   // Operating modes of the host_chip, as driven by its own state machine.
   typedef enum logic [2:0]
   {
      CHIP_INIT,
      CHIP_NORMAL,
      CHIP_SLEEP,
      CHIP_RESTART,
      CHIP_STOP,
      CHIP_FAILSAFE,
      CHIP_REPROG
   } linfc_chip_t;

   // Transceiver modes; low slope and normal slope share LIN_NORMAL.
   typedef enum logic [2:0]
   {
      LIN_OFF,
      LIN_WAKE,
      LIN_NORMAL,
      LIN_RXONLY,
      LIN_FLASH
   } linfc_mode_t;

   // Codes placed in the serial diagnostic data.
   typedef enum logic [2:0]
   {
      DIAG_NONE,
      DIAG_TXD_GND,
      DIAG_BUS_CLAMP,
      DIAG_SHORT,
      DIAG_RX_STUCK
   } linfc_diag_t;

   // Clock rate in MHz, so that microseconds times this give cycles.
   localparam int unsigned CLK_MHZ = 10;
   // Transmit dominant timeout in microseconds (plain default).
   localparam int unsigned TX_TO_US = 20000;
   localparam int unsigned TX_TO_CYC = TX_TO_US * CLK_MHZ;
   // Bus dominant timeout in microseconds (plain default).
   localparam int unsigned BUS_TO_US = 20000;
   localparam int unsigned BUS_TO_CYC = BUS_TO_US * CLK_MHZ;
   // Cycles of readback mismatch before a receive pin fault is declared.
   localparam int unsigned STUCK_CYC = 64;
   localparam int unsigned SHORT_CYC = 64;
   // Values after reset.
   localparam logic RECESSIVE = 1'h1;
   localparam logic SLOPE_RST = 1'h0;

endpackage : linfc_pkg

// ### rtl/linfc_level_timer.sv
// Saturating timer that measures how long a level condition has lasted.
// Assumes run comes from logic on the same clock.
`timescale 1ns/1ps
module linfc_level_timer
#(
   parameter int unsigned LIMIT = 64
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic run,
   output logic expired
);
   // Cycles that run has been high without a break.
   logic [31:0] count_q;
   logic [31:0] count_d;

   // Counting stops at the limit so the flag stays up while run holds.
   assign count_d = !run ? 32'h0 :
      (count_q == LIMIT) ? count_q : count_q + 32'h1;
   assign expired = (count_q == LIMIT);

   // Plain counter register.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         count_q <= 32'h0;
      end
      else
      begin
         count_q <= count_d;
      end
   end
endmodule : linfc_level_timer

// ### rtl/linfc_ctrl.sv
// Mode selection, wake detection and fault supervision of one LIN cell.
// Assumes chip_mode and commands come from logic on clk; pin inputs do not.
// Notes on behaviour
// R1: receive-only disables driver, keeps receive path
// R2: serial command selects receive-only mode
// R3: flash bypasses slope, only in reprogram mode
// R4: allowed transceiver modes depend on chip mode
// R5: automatic mode changes keep the same category
// R6: host arms wake mode before sleep/stop
// R7: host never changes mode with sleep command
// R8: wake capable or off removes bus pull-up
// R9: wake only on dominant-to-recessive bus edge
// R10: failures reported in diagnostics, overtemperature not
// R11: transmit timeout reported as input grounded
// R12: any failure forces receive-only mode; in reprogram chip mode the code keeps flash with the driver off
// R13: transmitter re-enabled only by serial request
// R14: long dominant transmit input stops bus driving
// R15: long dominant bus flags clamp, receive-only
// R16: unmasked clamp drives interrupt output low
// R17: host recommands normal mode after clamp
// R18: transmit-receive short reported and inhibits transmitter
// R19: overtemperature disables driver, reception continues
// R20: overtemperature release waits for recessive transmit
// R21: overtemperature gives no diagnostic, no interrupt
// R22: stuck recessive receive diagnosed, transmitter held off
// R23: stuck receive fault cleared only by command
// R24: slope resets low, normal slope in normal
// R25: after wake, other mode before rearming wake
// R26: stop-mode wake sets interrupt, flag, receive low
// R27: timeouts counted on clock, limits are parameters
// R28: receive readback compared with bus over cycles
`timescale 1ns/1ps
module linfc_ctrl
   import linfc_pkg::*;
#(
   parameter int unsigned TX_TO_LIMIT = TX_TO_CYC,
   parameter int unsigned BUS_TO_LIMIT = BUS_TO_CYC
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire linfc_chip_t chip_mode,
   input wire logic cmd_valid,
   input wire linfc_mode_t cmd_mode,
   input wire logic slope_valid,
   input wire logic slope_normal_req,
   input wire logic wake_clr,
   input wire logic wake_mask,
   input wire logic clamp_mask,
   input wire logic txd_pin,
   input wire logic bus_pin,
   input wire logic ovt_pin,
   input wire logic rxd_readback,
   output linfc_mode_t lin_mode,
   output logic driver_en,
   output logic bus_dominant,
   output logic pullup_en,
   output logic slope_bypass,
   output logic slope_normal,
   output logic rxd,
   output logic lin_wake_flag,
   output linfc_diag_t diag_code,
   output logic int_n
);
   // Modes that the current chip mode admits.
   function automatic logic mode_ok(linfc_chip_t c, linfc_mode_t m);
      logic ok;
      ok = 1'b0;
      case (c)
         CHIP_INIT: ok = (m == LIN_OFF);
         CHIP_NORMAL: ok = (m != LIN_FLASH);
         CHIP_FAILSAFE: ok = (m == LIN_WAKE);
         CHIP_REPROG: ok = (m == LIN_FLASH);
         default: ok = (m == LIN_OFF) || (m == LIN_WAKE);
      endcase
      return ok;
   endfunction : mode_ok

   // Automatic fallback when the chip mode forbids the present mode.
   function automatic linfc_mode_t fit_mode(linfc_chip_t c,
                                            linfc_mode_t m);
      linfc_mode_t r;
      r = m;
      if (!mode_ok(c, m))
      begin
         case (c)
            CHIP_FAILSAFE: r = LIN_WAKE;
            CHIP_REPROG: r = LIN_FLASH;
            CHIP_NORMAL: r = LIN_NORMAL;
            default: r = LIN_OFF;
         endcase
      end
      return r;
   endfunction : fit_mode

   // Pins are synchronised: bit 0 txd, 1 bus, 2 overtemp, 3 readback.
   logic [3:0] meta_q;
   logic [3:0] sync_q;
   logic txd_s;
   logic bus_s;
   logic ovt_s;
   logic rdb_s;
   // Previous synchronised levels for edge detection.
   logic txd_prev_q;
   logic bus_prev_q;
   // Stored mode as last chosen, before the overtemperature override.
   linfc_mode_t mode_q;
   linfc_mode_t mode_d;
   // Transmitter blocked by a reported fault.
   logic inhibit_q;
   logic inhibit_d;
   // Transmitter blocked by overtemperature.
   logic ot_block_q;
   logic ot_block_d;
   // Wake may be armed again only after another mode was chosen.
   logic wake_armed_q;
   logic wake_armed_d;
   // Timer flags and their previous values for one-shot events.
   logic [3:0] exp_w;
   logic [3:0] exp_prev_q;
   logic [3:0] hit_w;
   logic fault_evt;
   logic cmd_ok;
   logic cmd_normal;
   logic wake_evt;
   logic txd_rise;
   logic active;
   logic drv_d;
   linfc_diag_t diag_d;
   logic flag_d;
   // Every assertion in this module shares this clock and this reset.
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);

   assign txd_s = sync_q[0];
   assign bus_s = sync_q[1];
   assign ovt_s = sync_q[2];
   assign rdb_s = sync_q[3];

   // Two flops per pin; only the second stage is read anywhere.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         // Pins start at their idle levels: overtemperature clear and
         // transmit, bus and readback recessive, so no false edge follows.
         meta_q <= 4'hB;
         sync_q <= 4'hB;
         txd_prev_q <= RECESSIVE;
         bus_prev_q <= RECESSIVE;
         exp_prev_q <= 4'h0;
      end
      else
      begin
         meta_q <= {rxd_readback, ovt_pin, bus_pin, txd_pin};
         sync_q <= meta_q;
         txd_prev_q <= txd_s;
         bus_prev_q <= bus_s;
         exp_prev_q <= exp_w;
      end
   end

   // Supervisors only watch while the cell may transmit or receive.
   assign active = (mode_q == LIN_NORMAL) || (mode_q == LIN_FLASH) ||
      (mode_q == LIN_RXONLY);

   // Transmit input dominant too long; held at zero while inhibited.
   linfc_level_timer #(.LIMIT(TX_TO_LIMIT)) u_tx_to // see R14, R27
   (
      .clk(clk),
      .rstn(rstn),
      .run(!txd_s && !inhibit_q && active),
      .expired(exp_w[0])
   );

   // Bus dominant too long while the cell is awake.
   linfc_level_timer #(.LIMIT(BUS_TO_LIMIT)) u_bus_to // see R15, R27
   (
      .clk(clk),
      .rstn(rstn),
      .run(!bus_s && active),
      .expired(exp_w[1])
   );

   // Readback low while the bus is recessive and the input is low:
   // the transmit input is pulling the receive pin.
   linfc_level_timer #(.LIMIT(SHORT_CYC)) u_short // see R18, R28
   (
      .clk(clk),
      .rstn(rstn),
      .run(active && bus_s && !rdb_s && !txd_s),
      .expired(exp_w[2])
   );

   // Readback high while the bus carries a dominant level.
   linfc_level_timer #(.LIMIT(STUCK_CYC)) u_stuck // see R22, R28
   (
      .clk(clk),
      .rstn(rstn),
      .run(active && !bus_s && rdb_s),
      .expired(exp_w[3])
   );

   // One-cycle event on the rise of each supervisor flag.
   assign hit_w = exp_w & ~exp_prev_q;
   assign fault_evt = |hit_w; // see R12

   // A command is taken only where the chip mode admits it.
   assign cmd_ok = cmd_valid && mode_ok(chip_mode, cmd_mode) && // see R2, R4
      !((cmd_mode == LIN_WAKE) && !wake_armed_q); // see R25
   assign cmd_normal = cmd_ok && (cmd_mode == LIN_NORMAL); // see R13

   // Wake only on a bus edge back to recessive, so a shorted bus
   // can never wake the chip.
   assign wake_evt = (mode_q == LIN_WAKE) && wake_armed_q &&
      !bus_prev_q && bus_s; // see R9
   assign txd_rise = !txd_prev_q && txd_s;

   // Fault beats command; the chip mode then trims the choice.
   assign mode_d = fit_mode(chip_mode, // see R4, R5, R3
      fault_evt ? LIN_RXONLY : (cmd_ok ? cmd_mode : mode_q)); // see R12

   // Fault set wins over a clear that lands in the same cycle.
   // A stuck receive pin keeps the block for as long as it lasts.
   assign inhibit_d = fault_evt ? 1'b1 : // see R13, R14, R18
      ((cmd_normal && !exp_w[3]) ? 1'b0 : inhibit_q); // see R22, R23

   // Overtemperature clears only on a recessive edge of the input.
   assign ot_block_d = ovt_s ? 1'b1 : // see R19
      (txd_rise ? 1'b0 : ot_block_q); // see R20, R13

   // Wake capable may be armed again after any other commanded mode.
   assign wake_armed_d = wake_evt ? 1'b0 : // see R25
      ((cmd_ok && (cmd_mode != LIN_WAKE)) ? 1'b1 : wake_armed_q);

   // Driver runs only in normal or flash with no block present.
   assign drv_d = ((mode_d == LIN_NORMAL) || (mode_d == LIN_FLASH)) &&
      !inhibit_d && !ot_block_d; // see R1, R19

   // Timeout uses the grounded-input code; overtemp has none.
   assign diag_d = hit_w[0] ? DIAG_TXD_GND : // see R11
      hit_w[1] ? DIAG_BUS_CLAMP : // see R15
      hit_w[2] ? DIAG_SHORT : // see R18
      hit_w[3] ? DIAG_RX_STUCK : // see R22
      (cmd_normal ? DIAG_NONE : diag_code); // see R10, R21

   // Wake flag: a new wake wins over a clear in the same cycle.
   assign flag_d = wake_evt || (lin_wake_flag && !wake_clr); // see R26

   // Control state.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mode_q <= LIN_OFF;
         inhibit_q <= 1'b0;
         ot_block_q <= 1'b0;
         wake_armed_q <= 1'b1;
      end
      else
      begin
         mode_q <= mode_d;
         inhibit_q <= inhibit_d;
         ot_block_q <= ot_block_d;
         wake_armed_q <= wake_armed_d;
      end
   end

   // Output registers; every top-level output is a flop.
   // Receive follows the bus when awake; asleep, a pending wake pulls
   // it low so the controller can tell the source. The interrupt is a
   // level that stays low until its cause is cleared or masked.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         lin_mode <= LIN_OFF;
         driver_en <= 1'b0;
         bus_dominant <= 1'b0;
         pullup_en <= 1'b0;
         slope_bypass <= 1'b0;
         slope_normal <= SLOPE_RST;
         lin_wake_flag <= 1'b0;
         diag_code <= DIAG_NONE;
         rxd <= RECESSIVE;
         int_n <= 1'b1;
      end
      else
      begin
         // Overtemperature shows normal mode as receive-only while it blocks.
         lin_mode <= (ot_block_d && drv_d == 1'b0 &&
            (mode_d == LIN_NORMAL)) ? LIN_RXONLY : mode_d; // see R19
         driver_en <= drv_d; // see R1
         bus_dominant <= drv_d && !txd_s; // see R14
         pullup_en <= (mode_d != LIN_OFF) &&
            (mode_d != LIN_WAKE); // see R8
         slope_bypass <= (mode_d == LIN_FLASH); // see R3
         // Slope is shared by all cells and taken in chip normal only.
         slope_normal <= (slope_valid && (chip_mode == CHIP_NORMAL)) ?
            slope_normal_req : slope_normal; // see R24
         lin_wake_flag <= flag_d; // see R26
         diag_code <= diag_d; // see R10
         rxd <= ((mode_d == LIN_OFF) || (mode_d == LIN_WAKE)) ?
            !flag_d : bus_s; // see R1, R26
         int_n <= !((flag_d && !wake_mask && // see R26
            ((chip_mode == CHIP_STOP) || (chip_mode == CHIP_NORMAL))) ||
            ((diag_d == DIAG_BUS_CLAMP) && !clamp_mask)); // see R16
      end
   end

   // Receive-only never drives, yet keeps the receive path.
   a_rxonly_quiet: assert property // see R1
      ((lin_mode == LIN_RXONLY) |-> !driver_en && !bus_dominant)
      else $error("driver active in receive-only mode");
   // Slope bypass only follows the reprogram chip mode.
   a_flash_gate: assert property // see R3
      (slope_bypass |-> $past(chip_mode) == CHIP_REPROG)
      else $error("flash mode outside reprogram mode");
   // Init leaves nothing but off.
   a_init_off: assert property // see R4
      ($past(chip_mode) == CHIP_INIT |-> lin_mode == LIN_OFF)
      else $error("mode other than off in init");
   // Pull-up absent in wake capable and off.
   a_pullup_gate: assert property // see R8
      ((lin_mode inside {LIN_OFF, LIN_WAKE}) |-> !pullup_en)
      else $error("pull-up on while off or wake capable");
   // A rising wake flag needs a dominant then recessive bus before.
   a_wake_edge: assert property // see R9
      ($rose(lin_wake_flag) |-> $past(bus_s) && !$past(bus_prev_q))
      else $error("wake without recessive edge");
   // Steps of a fault seen in chip normal mode.
   sequence fault_in_normal;
      fault_evt && (chip_mode == CHIP_NORMAL);
   endsequence
   // A fault leaves the cell receive-only with the driver off.
   a_fault_rxonly: assert property // see R12
      (fault_in_normal |=> lin_mode == LIN_RXONLY && !driver_en)
      else $error("fault did not force receive-only");
   // The block holds until a normal-mode request arrives.
   a_inhibit_hold: assert property // see R13
      (inhibit_q && !cmd_normal |=> inhibit_q)
      else $error("transmitter re-enabled without request");
   // Overtemperature cleared but no recessive edge of the input yet.
   sequence ot_waiting;
      ot_block_q && !ovt_s && !txd_rise;
   endsequence
   // Release waits for the recessive edge and no longer.
   a_ot_release: assert property // see R20
      (ot_waiting |=> ot_block_q)
      else $error("overtemperature released too early");
   // Overtemperature alone leaves diagnostics untouched.
   a_ot_silent: assert property // see R21
      ($rose(ovt_s) && !fault_evt && !cmd_normal |=> $stable(diag_code))
      else $error("overtemperature reported");
   // Unmasked clamp pulls the interrupt low one cycle later.
   sequence clamp_seen;
      hit_w[1] && !hit_w[0] && !clamp_mask;
   endsequence
   a_clamp_int: assert property // see R16
      (clamp_seen |=> !int_n && diag_code == DIAG_BUS_CLAMP)
      else $error("clamp did not raise interrupt");

endmodule : linfc_ctrl

// ### testbench/linfc_partner.sv
// Far side of one LIN cell: the controller's transmit pin, the bus wire
// with its master pull-up, and the receive pin as read back by the chip.
// Assumes the bench changes the levels just after a rising clock edge.
`timescale 1ns/1ps
module linfc_partner
(
   input wire logic bus_dominant,
   input wire logic rxd,
   input wire logic tx_level,
   input wire logic ext_dom,
   input wire logic [1:0] rx_fault,
   output logic txd_pin,
   output logic bus_pin,
   output logic rxd_readback
);
   // The controller drives its transmit pin directly.
   assign txd_pin = tx_level;
   // Wired-and bus: the pull-up wins unless some node pulls it dominant.
   // The drive command is not gated here, so a stray one shows on the bus.
   assign bus_pin = !(bus_dominant || ext_dom);
   // Fault 1 shorts receive to transmit, fault 2 sticks it recessive.
   assign rxd_readback = (rx_fault == 2'h1) ? tx_level :
      ((rx_fault == 2'h2) ? 1'h1 : rxd);
endmodule : linfc_partner

// ### testbench/lin_transceiver_mode_fault_ctrl_test.sv
// Self-checking bench for the LIN cell mode and fault control.
// Assumes the partner model closes the loop between bus and pins.
`timescale 1ns/1ps
module lin_transceiver_mode_fault_ctrl_test;
   import linfc_pkg::*;
   // Short limits; the transmit limit stays above the 64-cycle short count.
   localparam int unsigned TXL = 100;
   localparam int unsigned BUSL = 150;
   logic clk = 1'h0;
   logic rstn = 1'h0;
   linfc_chip_t chip_mode = CHIP_INIT;
   logic cmd_valid = 1'h0;
   linfc_mode_t cmd_mode = LIN_OFF;
   logic slope_valid = 1'h0;
   logic slope_normal_req = 1'h0;
   logic wake_clr = 1'h0;
   logic wake_mask = 1'h0;
   logic clamp_mask = 1'h0;
   logic ovt_pin = 1'h0;
   logic tx_level = 1'h1;
   logic ext_dom = 1'h0;
   logic [1:0] rx_fault = 2'h0;
   logic txd_pin;
   logic bus_pin;
   logic rxd_readback;
   linfc_mode_t lin_mode;
   logic driver_en;
   logic bus_dominant;
   logic pullup_en;
   logic slope_bypass;
   logic slope_normal;
   logic rxd;
   logic lin_wake_flag;
   linfc_diag_t diag_code;
   logic int_n;
   int err_count = 0;
   int samples_checked = 0;

   // Free-running 10 MHz clock.
   initial
   begin
      forever #50 clk = ~clk;
   end

   // Masks stay open except where a scenario closes one on purpose.
   linfc_ctrl #(.TX_TO_LIMIT(TXL), .BUS_TO_LIMIT(BUSL)) dut_u
   (
      .clk(clk), .rstn(rstn), .chip_mode(chip_mode),
      .cmd_valid(cmd_valid), .cmd_mode(cmd_mode),
      .slope_valid(slope_valid), .slope_normal_req(slope_normal_req),
      .wake_clr(wake_clr), .wake_mask(wake_mask),
      .clamp_mask(clamp_mask),
      .txd_pin(txd_pin), .bus_pin(bus_pin), .ovt_pin(ovt_pin),
      .rxd_readback(rxd_readback), .lin_mode(lin_mode),
      .driver_en(driver_en), .bus_dominant(bus_dominant),
      .pullup_en(pullup_en), .slope_bypass(slope_bypass),
      .slope_normal(slope_normal), .rxd(rxd),
      .lin_wake_flag(lin_wake_flag), .diag_code(diag_code), .int_n(int_n)
   );

   linfc_partner partner_u
   (
      .bus_dominant(bus_dominant), .rxd(rxd), .tx_level(tx_level),
      .ext_dom(ext_dom), .rx_fault(rx_fault), .txd_pin(txd_pin),
      .bus_pin(bus_pin), .rxd_readback(rxd_readback)
   );

   // Prints the counts and the verdict, then ends the run.
   task summarize;
      $display("mismatches %0d of %0d checks", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : summarize

   // Compares a seen value with the expected one, four-state exact.
   task check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
         err_count = err_count + 1;
         $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : check

   // Waits a number of falling edges, where outputs have settled.
   task tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick

   // Selects the output watched by a bounded wait.
   function automatic logic pick(input int sel);
      case (sel)
         0: pick = (diag_code !== DIAG_NONE);
         1: pick = lin_wake_flag;
         2: pick = rxd;
         default: pick = driver_en;
      endcase
   endfunction : pick

   // Bounded wait; running out counts a mismatch and ends the run.
   task wait_for(input int sel, input logic v, input int n);
      int i;
      i = 0;
      while (pick(sel) !== v && i < n)
      begin
         @(negedge clk);
         i = i + 1;
      end
      check(pick(sel), v);
      if (pick(sel) !== v)
         summarize();
   endtask : wait_for

   // One-cycle mode command pulse; the answer lands at the next edge.
   task send(input linfc_mode_t m);
      @(posedge clk);
      cmd_valid <= 1'h1;
      cmd_mode <= m;
      @(posedge clk);
      cmd_valid <= 1'h0;
      @(negedge clk);
   endtask : send

   // One-cycle slope command pulse.
   task slope(input logic v);
      @(posedge clk);
      slope_valid <= 1'h1;
      slope_normal_req <= v;
      @(posedge clk);
      slope_valid <= 1'h0;
      @(negedge clk);
   endtask : slope

   // Changes the chip mode and waits out the one-cycle fit.
   task chip(input linfc_chip_t c);
      @(posedge clk);
      chip_mode <= c;
      repeat (2) @(negedge clk);
   endtask : chip

   // Sets transmit level, foreign dominant drive and receive pin fault.
   task drive(input logic t, input logic e, input logic [1:0] f);
      @(posedge clk);
      tx_level <= t;
      ext_dom <= e;
      rx_fault <= f;
      @(negedge clk);
   endtask : drive

   // Main sequence; each fault is cleared before the next one starts.
   initial
   begin
      repeat (2) @(negedge clk);
      check(lin_mode, LIN_OFF);
      check(pullup_en, 1'h0);
      check(slope_normal, SLOPE_RST);
      check({driver_en, rxd, int_n, lin_wake_flag}, 4'h6);
      @(posedge clk);
      rstn <= 1'h1;
      send(LIN_NORMAL);
      check(lin_mode, LIN_OFF);
      slope(1'h1);
      check(slope_normal, 1'h0);
      chip(CHIP_NORMAL);
      check(lin_mode, LIN_OFF);
      slope(1'h1);
      check(slope_normal, 1'h1);
      send(LIN_FLASH);
      check(lin_mode, LIN_OFF);
      send(LIN_NORMAL);
      check({pullup_en, driver_en, slope_bypass}, 3'h6);
      drive(1'h0, 1'h0, 2'h0);
      wait_for(2, 1'h0, 10);
      drive(1'h1, 1'h0, 2'h0);
      // Receive-only, then a transmit-to-receive short.
      send(LIN_RXONLY);
      check(driver_en, 1'h0);
      drive(1'h1, 1'h1, 2'h0);
      wait_for(2, 1'h0, 10);
      drive(1'h0, 1'h0, 2'h1);
      tick(4);
      check(bus_dominant, 1'h0);
      wait_for(0, 1'h1, 90);
      check(diag_code, DIAG_SHORT);
      drive(1'h1, 1'h0, 2'h0);
      send(LIN_NORMAL);
      check({diag_code, driver_en}, {DIAG_NONE, 1'h1});
      // Transmit held dominant past its limit.
      drive(1'h0, 1'h0, 2'h0);
      wait_for(0, 1'h1, TXL + 20);
      tick(2);
      check(diag_code, DIAG_TXD_GND);
      check({lin_mode, driver_en}, {LIN_RXONLY, 1'h0});
      check(bus_dominant, 1'h0);
      drive(1'h1, 1'h0, 2'h0);
      send(LIN_RXONLY);
      check(diag_code, DIAG_TXD_GND);
      send(LIN_NORMAL);
      check({diag_code, driver_en}, {DIAG_NONE, 1'h1});
      // Bus clamped dominant by a foreign node.
      drive(1'h1, 1'h1, 2'h0);
      wait_for(0, 1'h1, BUSL + 20);
      tick(2);
      check(diag_code, DIAG_BUS_CLAMP);
      check({lin_mode, driver_en, int_n}, {LIN_RXONLY, 2'h0});
      // A closed mask lifts the interrupt while the clamp stays pending.
      @(posedge clk);
      clamp_mask <= 1'h1;
      tick(2);
      check(int_n, 1'h1);
      @(posedge clk);
      clamp_mask <= 1'h0;
      drive(1'h1, 1'h0, 2'h0);
      send(LIN_NORMAL);
      check({diag_code, driver_en}, {DIAG_NONE, 1'h1});
      // Receive pin stuck recessive under bus traffic.
      drive(1'h1, 1'h1, 2'h2);
      wait_for(0, 1'h1, 90);
      tick(2);
      check({diag_code, driver_en}, {DIAG_RX_STUCK, 1'h0});
      send(LIN_NORMAL);
      check(driver_en, 1'h0);
      drive(1'h1, 1'h0, 2'h0);
      tick(4);
      check(driver_en, 1'h0);
      send(LIN_NORMAL);
      check({diag_code, driver_en}, {DIAG_NONE, 1'h1});
      // Overtemperature: silent, and released only by a recessive edge.
      @(posedge clk);
      ovt_pin <= 1'h1;
      wait_for(3, 1'h0, 6);
      check(lin_mode, LIN_RXONLY);
      drive(1'h1, 1'h1, 2'h0);
      wait_for(2, 1'h0, 10);
      drive(1'h1, 1'h0, 2'h0);
      check({diag_code, int_n}, {DIAG_NONE, 1'h1});
      @(posedge clk);
      ovt_pin <= 1'h0;
      tick(6);
      check(driver_en, 1'h0);
      drive(1'h0, 1'h0, 2'h0);
      tick(4);
      drive(1'h1, 1'h0, 2'h0);
      wait_for(3, 1'h1, 8);
      // Wake capable before stop, and a wake on the recessive edge.
      send(LIN_WAKE);
      check(pullup_en, 1'h0);
      chip(CHIP_STOP);
      check(lin_mode, LIN_WAKE);
      drive(1'h1, 1'h1, 2'h0);
      tick(12);
      check(lin_wake_flag, 1'h0);
      drive(1'h1, 1'h0, 2'h0);
      wait_for(1, 1'h1, 8);
      tick(1);
      check({rxd, int_n}, 2'h0);
      @(posedge clk);
      wake_mask <= 1'h1;
      tick(2);
      check(int_n, 1'h1);
      @(posedge clk);
      wake_clr <= 1'h1;
      wake_mask <= 1'h0;
      @(posedge clk);
      wake_clr <= 1'h0;
      tick(2);
      check(lin_wake_flag, 1'h0);
      send(LIN_OFF);
      check({lin_mode, pullup_en}, {LIN_OFF, 1'h0});
      send(LIN_WAKE);
      check(lin_mode, LIN_WAKE);
      // Chip mode changes force or keep the transceiver mode.
      chip(CHIP_NORMAL);
      send(LIN_NORMAL);
      chip(CHIP_FAILSAFE);
      check(lin_mode, LIN_WAKE);
      chip(CHIP_SLEEP);
      check(lin_mode, LIN_WAKE);
      chip(CHIP_REPROG);
      check({lin_mode, slope_bypass}, {LIN_FLASH, 1'h1});
      chip(CHIP_NORMAL);
      check({lin_mode, slope_bypass}, {LIN_NORMAL, 1'h0});
      send(LIN_OFF);
      chip(CHIP_STOP);
      check(lin_mode, LIN_OFF);
      summarize();
   end
endmodule : lin_transceiver_mode_fault_ctrl_test
